// ### acc_pkg.sv
// Purpose: shared constants for the analog compare control block
// Assumes: 8-bit register data, 13-bit register address
// Notes: offsets are byte addresses on the plain register port
package acc_pkg;
  // ---------------------------------------------------------------
  // Bus shape
  // ---------------------------------------------------------------
  localparam int ACC_ADDR_W = 13;
  localparam int ACC_DATA_W = 8;
  localparam int ACC_NUM_COMP = 2;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [12:0] ACC_COP_SEC_OFS = 13'h1ff0;
  localparam logic [12:0] ACC_STAT_OFS = 13'h001e;
  localparam logic [12:0] ACC_CTRL_OFS = 13'h001c;
  localparam logic [12:0] ACC_MUX_OFS = 13'h001d;
  localparam logic [12:0] ACC_IST_OFS = 13'h0020;
  localparam logic [12:0] ACC_IMSK_OFS = 13'h0021;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int ACC_COP_SEC_OPTION_BIT = 1;
  localparam int ACC_STAT_CMP1_BIT = 0;
  localparam int ACC_STAT_CMP2_BIT = 1;
  localparam int ACC_STAT_OFFSET_BIT = 4;
  localparam int ACC_STAT_OUT_EN_BIT = 5;
  localparam int ACC_CTRL_METHOD_LO_BIT = 0;
  localparam int ACC_CTRL_METHOD_HI_BIT = 1;
  localparam int ACC_CTRL_CHARGE_BIT = 2;
  localparam int ACC_CTRL_SRC_EN_BIT = 3;
  localparam int ACC_MUX_CHAN_LSB = 0;
  localparam int ACC_MUX_REF_BIT = 4;
  localparam int ACC_MUX_DIV_BIT = 5;
  localparam int ACC_MUX_HOLD_BIT = 6;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] ACC_REG_RESET = 8'h00;
  localparam logic [1:0] ACC_FLAG_RESET = 2'h0;
endpackage

// ### acc_sync.sv
// Purpose: two-stage synchroniser for the comparator outputs
// Assumes: inputs are asynchronous analog comparator levels
// Notes: first stage feeds only the second stage
`timescale 1ns/100ps
module acc_sync
  import acc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [ACC_NUM_COMP-1:0] async_in,
  output logic [ACC_NUM_COMP-1:0] sync_out
);
  logic [ACC_NUM_COMP-1:0] meta_reg;
  logic [ACC_NUM_COMP-1:0] sync_reg;

  // ---------------------------------------------------------------
  // One pair of flops per comparator
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < ACC_NUM_COMP; gi++)
    begin : g_sync
      always_ff @(posedge sys_clk)
      begin
        if (!resetn)
        begin
          meta_reg[gi] <= 1'b0;
          sync_reg[gi] <= 1'b0;
        end
        else
        begin
          meta_reg[gi] <= async_in[gi];
          sync_reg[gi] <= meta_reg[gi];
        end
      end
    end
  endgenerate

  assign sync_out = sync_reg;
endmodule // acc_sync

// ### acc_top.sv
// Purpose: control logic around the ramp-type analog comparators
// Assumes: comparator outputs arrive asynchronously; mode and port
//   inputs come from logic on sys_clk
// Notes: every output is registered, so it lags its next-state logic by one edge
`timescale 1ns/100ps
module acc_top
  import acc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [ACC_ADDR_W-1:0] reg_addr,
  input wire logic [ACC_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ACC_DATA_W-1:0] reg_rdata,
  input wire logic comp_one_raw,
  input wire logic comp_two_raw,
  input wire logic port_data_bit4,
  input wire logic timer_output_level,
  input wire logic wait_mode,
  input wire logic stop_mode,
  output logic comparator_output_pin_out,
  output logic comparator_output_pin_oe,
  output logic ramp_capacitor_pin_out,
  output logic ramp_capacitor_pin_oe,
  output logic charge_current_drive,
  output logic sample_offset_enable,
  output logic temp_diode_select,
  output logic temp_diode_bias_on,
  output logic supply_reference_connect,
  output logic [3:0] channel_connect,
  output logic divided_sample_out,
  output logic analog_irq,
  output logic wake_request
);
  // ---------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------
  logic option_reg;
  logic comparator_one_output_enable_reg;
  logic voff_reg;
  logic [3:0] ctrl_reg;
  logic [6:0] mux_reg;
  logic [1:0] flag_reg;
  logic [1:0] flag_next;
  logic [1:0] mask_reg;
  logic [1:0] comp_sync;
  logic [1:0] comp_prev_reg;
  logic [ACC_DATA_W-1:0] rdata_next;

  // Comparator levels cross into sys_clk first
  acc_sync u_sync (
    .sys_clk (sys_clk),
    .resetn (resetn),
    .async_in ({comp_two_raw, comp_one_raw}),
    .sync_out (comp_sync)
  );

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  wire hit_cop_sec = reg_addr == ACC_COP_SEC_OFS;
  wire hit_stat = reg_addr == ACC_STAT_OFS;
  wire hit_ctrl = reg_addr == ACC_CTRL_OFS;
  wire hit_mux = reg_addr == ACC_MUX_OFS;
  wire hit_ist = reg_addr == ACC_IST_OFS;
  wire hit_imsk = reg_addr == ACC_IMSK_OFS;

  // Field views
  wire current_source_enable = ctrl_reg[ACC_CTRL_SRC_EN_BIT];
  wire charge_current_on = ctrl_reg[ACC_CTRL_CHARGE_BIT];
  wire conversion_method_select_lo = ctrl_reg[ACC_CTRL_METHOD_LO_BIT];
  wire conversion_method_select_hi = ctrl_reg[ACC_CTRL_METHOD_HI_BIT];
  wire [3:0] channel_select = mux_reg[ACC_MUX_CHAN_LSB +: 4];
  wire reference_select = mux_reg[ACC_MUX_REF_BIT];
  wire divided_sample_select = mux_reg[ACC_MUX_DIV_BIT];
  wire hold_select = mux_reg[ACC_MUX_HOLD_BIT];

  // ---------------------------------------------------------------
  // Derived analog controls
  // ---------------------------------------------------------------
  // Manual mode 0 is both method bits clear
  wire manual_mode0 = !conversion_method_select_lo && !conversion_method_select_hi;
  // Charging needs all three conditions at once
  wire charge_next = current_source_enable && manual_mode0
                     && charge_current_on;
  // Discharge only possible with the source enabled; off while charging
  wire discharge_next = current_source_enable && !charge_next;
  // Diode shares the hold pair decode
  wire diode_next = hold_select && divided_sample_select;
  // Supply reference only with every channel bit clear
  wire supply_ref_next = reference_select && (channel_select == 4'h0);
  // Pin value: OR of comparator, port data and timer level; drive enable is option AND output enable
  wire pin_drive_en_next = option_reg && comparator_one_output_enable_reg;
  wire pin_value_next = comp_sync[0] || port_data_bit4 || timer_output_level;
  // Offset feature also gated by the option bit
  wire offset_next = option_reg && voff_reg;

  // ---------------------------------------------------------------
  // Comparator events and interrupt
  // ---------------------------------------------------------------
  // Rising edge of each synchronised comparator output
  wire [1:0] comp_event = comp_sync & ~comp_prev_reg;
  wire [1:0] flag_clear = (reg_wr && hit_ist) ? reg_wdata[1:0] : 2'h0;
  wire irq_pending = |(flag_reg & mask_reg);
  // Stop mode cannot restart the core; the pin path stays the only route
  wire irq_next = irq_pending && !stop_mode;
  wire wake_next = irq_pending && wait_mode && !stop_mode;

  // Set beats a write-one clear in the same cycle
  always_comb
  begin
    flag_next = (flag_reg & ~flag_clear) | comp_event;
  end

  // ---------------------------------------------------------------
  // Read mux, registered for one-cycle-later data
  // ---------------------------------------------------------------
  always_comb
  begin
    rdata_next = ACC_REG_RESET;
    if (!reg_rd)
      rdata_next = ACC_REG_RESET;
    else if (hit_cop_sec)
      rdata_next[ACC_COP_SEC_OPTION_BIT] = option_reg;
    else if (hit_stat)
    begin
      rdata_next[ACC_STAT_CMP1_BIT] = comp_sync[0];
      rdata_next[ACC_STAT_CMP2_BIT] = comp_sync[1];
      rdata_next[ACC_STAT_OFFSET_BIT] = voff_reg;
      rdata_next[ACC_STAT_OUT_EN_BIT] = comparator_one_output_enable_reg;
    end
    else if (hit_ctrl)
      rdata_next[3:0] = ctrl_reg;
    else if (hit_mux)
      rdata_next[6:0] = mux_reg;
    else if (hit_ist)
      rdata_next[1:0] = flag_reg;
    else if (hit_imsk)
      rdata_next[1:0] = mask_reg;
  end

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  // Writes land at the strobe's own edge
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      option_reg <= 1'b0;
      comparator_one_output_enable_reg <= 1'b0;
      voff_reg <= 1'b0;
      ctrl_reg <= 4'h0;
      mux_reg <= 7'h00;
      mask_reg <= ACC_FLAG_RESET;
    end
    else if (reg_wr)
    begin
      if (hit_cop_sec)
        option_reg <= reg_wdata[ACC_COP_SEC_OPTION_BIT];
      if (hit_stat)
      begin
        comparator_one_output_enable_reg <= reg_wdata[ACC_STAT_OUT_EN_BIT];
        voff_reg <= reg_wdata[ACC_STAT_OFFSET_BIT];
      end
      if (hit_ctrl)
        ctrl_reg <= reg_wdata[3:0];
      if (hit_mux)
        mux_reg <= reg_wdata[6:0];
      if (hit_imsk)
        mask_reg <= reg_wdata[1:0];
    end
  end

  // Event flags and edge history
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      flag_reg <= ACC_FLAG_RESET;
      comp_prev_reg <= 2'h0;
    end
    else
    begin
      flag_reg <= flag_next;
      comp_prev_reg <= comp_sync;
    end
  end

  // ---------------------------------------------------------------
  // Output flops
  // ---------------------------------------------------------------
  // Every pin-facing signal is registered to keep glitches off pads
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      reg_rdata <= ACC_REG_RESET;
      comparator_output_pin_out <= 1'b0;
      comparator_output_pin_oe <= 1'b0;
      ramp_capacitor_pin_out <= 1'b0;
      ramp_capacitor_pin_oe <= 1'b0;
      charge_current_drive <= 1'b0;
      sample_offset_enable <= 1'b0;
      temp_diode_select <= 1'b0;
      temp_diode_bias_on <= 1'b0;
      supply_reference_connect <= 1'b0;
      channel_connect <= 4'h0;
      divided_sample_out <= 1'b0;
      analog_irq <= 1'b0;
      wake_request <= 1'b0;
    end
    else
    begin
      reg_rdata <= rdata_next;
      comparator_output_pin_out <= pin_value_next;
      comparator_output_pin_oe <= pin_drive_en_next;
      ramp_capacitor_pin_out <= 1'b0;
      ramp_capacitor_pin_oe <= discharge_next;
      charge_current_drive <= charge_next;
      sample_offset_enable <= offset_next;
      temp_diode_select <= diode_next;
      temp_diode_bias_on <= diode_next;
      supply_reference_connect <= supply_ref_next;
      channel_connect <= channel_select;
      divided_sample_out <= divided_sample_select;
      analog_irq <= irq_next;
      wake_request <= wake_next;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // Control write followed by the visible effect
  sequence s_ctrl_write;
    reg_wr && hit_ctrl;
  endsequence
  sequence s_ctrl_seen;
    ctrl_reg == $past(reg_wdata[3:0]);
  endsequence

  a_option_gates_pin: assert property (
    !option_reg |=> !comparator_output_pin_oe && !sample_offset_enable)
    else $error("pin drive or offset active with option bit clear");

  a_pin_or_value: assert property (
    option_reg && comparator_one_output_enable_reg |=> comparator_output_pin_oe
      && comparator_output_pin_out == $past(comp_sync[0] || port_data_bit4
      || timer_output_level))
    else $error("comparator pin does not show the OR of its sources");

  a_wait_wakes: assert property (
    irq_pending && wait_mode && !stop_mode |=> wake_request && analog_irq)
    else $error("pending comparator event did not wake from wait");

  a_stop_no_wake: assert property (
    stop_mode |=> !wake_request && !analog_irq)
    else $error("comparator event restarted core in stop");

  a_current_source_enable_off_quiet: assert property (
    !current_source_enable |=> !charge_current_drive && !ramp_capacitor_pin_oe)
    else $error("ramp source active with current source disabled");

  a_discharge_low: assert property (
    ramp_capacitor_pin_oe |-> !ramp_capacitor_pin_out && $past(current_source_enable))
    else $error("discharge not pulling low or not enabled");

  a_charge_cond: assert property (
    current_source_enable && manual_mode0 && charge_current_on
      |=> charge_current_drive && !ramp_capacitor_pin_oe)
    else $error("charge current missing in manual mode 0");

  a_diode_select: assert property (
    $rose(hold_select && divided_sample_select) |=> temp_diode_select)
    else $error("hold pair did not select the diode");

  a_bias_follows: assert property (
    temp_diode_bias_on == temp_diode_select)
    else $error("diode bias differs from diode selection");

  a_supply_ref: assert property (
    supply_reference_connect |-> $past(reference_select)
      && channel_connect == 4'h0)
    else $error("supply reference with channel bits set");

  a_chan_route: assert property (
    1'b1 |=> channel_connect == $past(channel_select))
    else $error("channel bus routing wrong");

  a_write_effect: assert property (
    s_ctrl_write |=> s_ctrl_seen ##1 charge_current_drive == $past(charge_next))
    else $error("control write did not take effect at its edge");

  a_flag_set_wins: assert property (
    comp_event[0] |=> flag_reg[0])
    else $error("comparator event lost against a clear");
endmodule // acc_top

// ### tb_top.sv
// Purpose: self-checking bench for the analog compare control block
// Assumes: registered outputs, read data valid only the cycle after the strobe
// Notes: stimulus changes by non-blocking assignment at the rising edge
`timescale 1ns/100ps
module tb_top
  import acc_pkg::*;
;
  // ---------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [ACC_ADDR_W-1:0] reg_addr = '0;
  logic [ACC_DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [ACC_DATA_W-1:0] reg_rdata;
  logic comp_one_raw = 1'b0;
  logic comp_two_raw = 1'b0;
  logic port_data_bit4 = 1'b0;
  logic timer_output_level = 1'b0;
  logic wait_mode = 1'b0;
  logic stop_mode = 1'b0;
  logic comparator_output_pin_out, comparator_output_pin_oe;
  logic ramp_capacitor_pin_out, ramp_capacitor_pin_oe, charge_current_drive;
  logic sample_offset_enable, temp_diode_select, temp_diode_bias_on;
  logic supply_reference_connect, divided_sample_out, analog_irq, wake_request;
  logic [3:0] channel_connect;
  int err_count = 0;
  int checked = 0;
  logic [12:0] ofs [6] = '{ACC_COP_SEC_OFS, ACC_STAT_OFS, ACC_CTRL_OFS, ACC_MUX_OFS,
    ACC_IST_OFS, ACC_IMSK_OFS};

  // 200 MHz system clock
  always #2.5 sys_clk = ~sys_clk;

  acc_top uut (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .comp_one_raw(comp_one_raw), .comp_two_raw(comp_two_raw),
    .port_data_bit4(port_data_bit4), .timer_output_level(timer_output_level),
    .wait_mode(wait_mode), .stop_mode(stop_mode),
    .comparator_output_pin_out(comparator_output_pin_out),
    .comparator_output_pin_oe(comparator_output_pin_oe),
    .ramp_capacitor_pin_out(ramp_capacitor_pin_out),
    .ramp_capacitor_pin_oe(ramp_capacitor_pin_oe),
    .charge_current_drive(charge_current_drive),
    .sample_offset_enable(sample_offset_enable), .temp_diode_select(temp_diode_select),
    .temp_diode_bias_on(temp_diode_bias_on),
    .supply_reference_connect(supply_reference_connect),
    .channel_connect(channel_connect), .divided_sample_out(divided_sample_out),
    .analog_irq(analog_irq), .wake_request(wake_request));

  // ---------------------------------------------------------------
  // Compare, bus and wait tasks
  // ---------------------------------------------------------------
  task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data is looked at only in the one cycle it stands
  task automatic rd(input logic [12:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk_data(reg_rdata, exp);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Bounded wait; a hang counts as a mismatch
  task automatic wait_irq;
    int n;
    n = 0;
    while (analog_irq !== 1'b1 && n < 10)
    begin
      settle(1);
      n++;
    end
    if (analog_irq !== 1'b1)
    begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, analog_irq, 1'b1);
      err_count++;
      wrap_up();
    end
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    settle(1);
    // Everything quiet out of reset
    chk_data({ramp_capacitor_pin_oe, charge_current_drive, sample_offset_enable,
      temp_diode_select, supply_reference_connect, comparator_output_pin_oe,
      analog_irq, wake_request}, 8'h00);
    foreach (ofs[i]) rd(ofs[i], 8'h00);
    $display("test reset done");

    // Option bit gates pin drive and offset; pin is a three-way OR
    // Timer capture interrupt is taken as off while comparator 1 is used
    wr(ACC_STAT_OFS, 8'hff);
    settle(2);
    chk_bit(comparator_output_pin_oe, 1'b0);
    chk_bit(sample_offset_enable, 1'b0);
    wr(ACC_COP_SEC_OFS, 8'hff);
    settle(2);
    chk_bit(comparator_output_pin_oe, 1'b1);
    chk_bit(sample_offset_enable, 1'b1);
    rd(ACC_COP_SEC_OFS, 8'h02);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge sys_clk);
      comp_one_raw <= i[0];
      port_data_bit4 <= i[1];
      timer_output_level <= i[2];
      settle(5);
      chk_bit(comparator_output_pin_out, |i[2:0]);
    end
    rd(ACC_STAT_OFS, 8'h31);
    wr(ACC_COP_SEC_OFS, 8'h00);
    settle(2);
    chk_bit(comparator_output_pin_oe, 1'b0);
    chk_bit(sample_offset_enable, 1'b0);
    $display("test option_pin done");

    // Every method, charge and enable combination of the control register
    for (int i = 0; i < 16; i++)
    begin
      wr(ACC_CTRL_OFS, 8'(i));
      settle(2);
      chk_bit(charge_current_drive, i[3] & i[2] & ~i[1] & ~i[0]);
      chk_bit(ramp_capacitor_pin_oe, i[3] & ~(i[2] & ~i[1] & ~i[0]));
      chk_bit(ramp_capacitor_pin_out, 1'b0);
      rd(ACC_CTRL_OFS, 8'(i));
    end
    $display("test current_source done");

    // Every multiplex setting: diode, supply reference, channels
    for (int i = 0; i < 128; i++)
    begin
      wr(ACC_MUX_OFS, 8'(i));
      settle(2);
      chk_bit(temp_diode_select, i[6] & i[5]);
      chk_bit(temp_diode_bias_on, i[6] & i[5]);
      chk_data({4'h0, channel_connect}, {4'h0, i[3:0]});
      chk_bit(divided_sample_out, i[5]);
      if (i[3:0] == 4'h0)
        chk_bit(supply_reference_connect, i[4]);
    end
    rd(ACC_MUX_OFS, 8'h7f);
    // Supply reference read the way software should do it: halved input
    wr(ACC_MUX_OFS, 8'h30);
    settle(2);
    chk_bit(supply_reference_connect, 1'b1);
    chk_bit(divided_sample_out, 1'b1);
    $display("test multiplex done");

    // Comparator events: wait wakes, stop never does, mask and clear
    wr(ACC_IMSK_OFS, 8'hff);
    rd(ACC_IMSK_OFS, 8'h03);
    wr(ACC_IMSK_OFS, 8'h01);
    @(posedge sys_clk);
    comp_one_raw <= 1'b0;
    settle(5);
    wr(ACC_IST_OFS, 8'h03);
    settle(2);
    chk_bit(analog_irq, 1'b0);
    @(posedge sys_clk);
    wait_mode <= 1'b1;
    comp_one_raw <= 1'b1;
    wait_irq();
    settle(2);
    chk_bit(wake_request, 1'b1);
    @(posedge sys_clk);
    stop_mode <= 1'b1;
    settle(2);
    chk_bit(analog_irq, 1'b0);
    chk_bit(wake_request, 1'b0);
    rd(ACC_IST_OFS, 8'h01);
    @(posedge sys_clk);
    stop_mode <= 1'b0;
    settle(2);
    chk_bit(analog_irq, 1'b1);
    wr(ACC_IMSK_OFS, 8'h00);
    settle(2);
    chk_bit(analog_irq, 1'b0);
    @(posedge sys_clk);
    comp_two_raw <= 1'b1;
    settle(6);
    chk_bit(analog_irq, 1'b0);
    rd(ACC_IST_OFS, 8'h03);
    rd(ACC_STAT_OFS, 8'h33);
    wr(ACC_IMSK_OFS, 8'h02);
    settle(2);
    chk_bit(analog_irq, 1'b1);
    wr(ACC_IST_OFS, 8'h03);
    settle(2);
    chk_bit(analog_irq, 1'b0);
    chk_bit(wake_request, 1'b0);
    $display("test interrupt done");

    // Unmapped place, then a second reset in mid-run
    wr(13'h0100, 8'hff);
    rd(13'h0100, 8'h00);
    @(posedge sys_clk);
    wait_mode <= 1'b0;
    comp_one_raw <= 1'b0;
    comp_two_raw <= 1'b0;
    wr(ACC_CTRL_OFS, 8'h0f);
    settle(5);
    @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    settle(1);
    foreach (ofs[i]) rd(ofs[i], 8'h00);
    chk_bit(ramp_capacitor_pin_oe, 1'b0);
    $display("test second_reset done");
    wrap_up();
  end
endmodule // tb_top
